//--- common/velocity_threshold_pkg.sv
// Shared constants for the velocity threshold and mode select logic.
// Assumes a single 200 MHz clock and the device register port address space.
package velocity_threshold_pkg;

    // Register port geometry.
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int THR_W = 20;

    // Register addresses (register indices on the device register port).
    localparam logic [6:0] ADDR_MEASURED_STEP_INTERVAL = 7'h14;
    localparam logic [6:0] ADDR_COOL_LOW_VELOCITY_THRESHOLD = 7'h16;
    localparam logic [6:0] ADDR_HIGH_VELOCITY_THRESHOLD = 7'h17;

    // Reset values and the interval saturation value.
    localparam logic [19:0] THRESHOLD_RESET = 20'h00000;
    localparam logic [19:0] INTERVAL_RESET = 20'h00000;
    localparam logic [19:0] INTERVAL_MAX = 20'hFFFFF;

    // Hysteresis shifts: 1/16 normally, 1/32 with the narrow flag.
    localparam int HYST_SHIFT_WIDE = 4;
    localparam int HYST_SHIFT_NARROW = 5;

    // Stall suppression after a high-speed crossing, counted in microsteps.
    localparam int ELEC_PERIOD_USTEPS = 1024;
    localparam int SUPPRESS_PERIODS = 2;
    localparam int SUPPRESS_USTEPS = ELEC_PERIOD_USTEPS * SUPPRESS_PERIODS;
    localparam int SUPPRESS_CNT_W = 12;

    // Threshold channel indices.
    localparam int CH_LOW = 0;
    localparam int CH_HIGH = 1;
    localparam int NUM_CH = 2;

    // Stall suppression state machine.
    typedef enum logic [1:0] {
        SUP_IDLE = 2'b01,
        SUP_ACTIVE = 2'b10
    } suppress_state_t;

endpackage : velocity_threshold_pkg

//--- logic/threshold_hysteresis_compare.sv
// One step-interval threshold comparator with hysteresis.
// Assumes interval and threshold are synchronous to clk and stable per cycle.
`timescale 1ns/1ps
module threshold_hysteresis_compare #(
    parameter int WIDTH = 20
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] interval,
    input wire logic [WIDTH-1:0] threshold,
    input wire logic narrow_hysteresis,
    output logic at_or_under
);

    typedef struct packed {
        logic under;
    } cmp_state_t;

    cmp_state_t state;
    cmp_state_t next_state;
    logic [WIDTH-1:0] hyst;
    logic [WIDTH-1:0] second_value;

    ////////////////////////////////////////////////////////////////////////////
    // Entering needs interval below threshold minus hysteresis; leaving needs
    // interval above the threshold itself, so jitter cannot toggle the mode.
    always_comb begin
        next_state = state;
        if (narrow_hysteresis) begin
            hyst = threshold >> velocity_threshold_pkg::HYST_SHIFT_NARROW;
        end else begin
            hyst = threshold >> velocity_threshold_pkg::HYST_SHIFT_WIDE;
        end
        second_value = threshold - hyst;
        if (!state.under && (interval < second_value)) begin
            next_state.under = 1'b1;
        end else if (state.under && (interval > threshold)) begin
            next_state.under = 1'b0;
        end
    end

    // State register, re-evaluated every cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign at_or_under = state.under;

endmodule : threshold_hysteresis_compare

//--- logic/velocity_threshold_mode_select.sv
// Velocity threshold comparators and mode enables of the stepper driver.
// Assumes a device register port with single-cycle write strobes, a one-cycle
// pulse per 1/256 microstep, and all configuration bits synchronous to clk.
`timescale 1ns/1ps
module velocity_threshold_mode_select #(
    parameter int THR_W = velocity_threshold_pkg::THR_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] reg_addr,
    input wire logic reg_write,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic microstep_pulse,
    input wire logic small_hysteresis,
    input wire logic current_scaling_config,
    input wire logic stop_on_stall_enable,
    input wire logic stall_output_config,
    input wire logic load_step_mode,
    input wire logic high_speed_chopper_switch,
    input wire logic high_speed_full_step,
    output logic [THR_W-1:0] measured_step_interval,
    output logic current_scaling_active,
    output logic stop_on_stall_armed,
    output logic stall_to_diagnostic_outputs,
    output logic voltage_pwm_allowed,
    output logic force_chopper_mode_one,
    output logic fast_decay_time_zero,
    output logic full_step_active,
    output logic step_mode_stall_detect,
    output logic stall_detect_suppressed
);

    typedef struct packed {
        logic [THR_W-1:0] lower_velocity_threshold;
        logic [THR_W-1:0] high_speed_threshold;
        logic [THR_W-1:0] step_count;
        logic [THR_W-1:0] interval;
        logic [31:0] rdata;
        velocity_threshold_pkg::suppress_state_t sup_state;
        logic [velocity_threshold_pkg::SUPPRESS_CNT_W-1:0] sup_count;
        logic high_prev;
        logic stall_armed;
        logic scaling;
        logic stop_armed;
        logic stall_out;
        logic pwm_allowed;
        logic chm_one;
        logic decay_zero;
        logic full_step;
        logic step_stall;
    } mode_state_t;

    localparam logic [velocity_threshold_pkg::SUPPRESS_CNT_W-1:0] SUP_LAST =
        velocity_threshold_pkg::SUPPRESS_CNT_W'(velocity_threshold_pkg::SUPPRESS_USTEPS - 1);
    localparam logic [THR_W-1:0] INTERVAL_MAX = velocity_threshold_pkg::INTERVAL_MAX;

    mode_state_t state;
    mode_state_t next_state;
    logic [velocity_threshold_pkg::NUM_CH-1:0][THR_W-1:0] thr_vec;
    logic [velocity_threshold_pkg::NUM_CH-1:0] under_vec;
    logic under_low;
    logic under_high;
    logic crossing;
    logic step_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Threshold comparators, one per threshold register.
    assign thr_vec[velocity_threshold_pkg::CH_LOW] = state.lower_velocity_threshold;
    assign thr_vec[velocity_threshold_pkg::CH_HIGH] = state.high_speed_threshold;

    // Both comparators watch the same interval and hysteresis setting.
    generate
        for (genvar ch = 0; ch < velocity_threshold_pkg::NUM_CH; ch++) begin : g_cmp
            threshold_hysteresis_compare #(
                .WIDTH(THR_W)
            ) u_cmp (
                .clk(clk),
                .rst_b(rst_b),
                .interval(state.interval),
                .threshold(thr_vec[ch]),
                .narrow_hysteresis(small_hysteresis),
                .at_or_under(under_vec[ch])
            );
        end
    endgenerate

    // Region decode and derived terms.
    assign under_low = under_vec[velocity_threshold_pkg::CH_LOW];
    assign under_high = under_vec[velocity_threshold_pkg::CH_HIGH];
    assign crossing = under_high ^ state.high_prev;
    assign step_mode = load_step_mode | (under_high & high_speed_full_step);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: registers, interval measurement, suppression, enables.
    always_comb begin
        next_state = state;

        // Register writes keep the low 20 bits; upper bits are not stored.
        if (reg_write) begin
            if (reg_addr == velocity_threshold_pkg::ADDR_COOL_LOW_VELOCITY_THRESHOLD) begin
                next_state.lower_velocity_threshold = reg_wdata[THR_W-1:0];
            end
            if (reg_addr == velocity_threshold_pkg::ADDR_HIGH_VELOCITY_THRESHOLD) begin
                next_state.high_speed_threshold = reg_wdata[THR_W-1:0];
            end
        end

        // Read data is registered from the current address every cycle.
        unique case (reg_addr)
            velocity_threshold_pkg::ADDR_MEASURED_STEP_INTERVAL: begin
                next_state.rdata = {12'h000, state.interval};
            end
            velocity_threshold_pkg::ADDR_COOL_LOW_VELOCITY_THRESHOLD: begin
                next_state.rdata = {12'h000, state.lower_velocity_threshold};
            end
            velocity_threshold_pkg::ADDR_HIGH_VELOCITY_THRESHOLD: begin
                next_state.rdata = {12'h000, state.high_speed_threshold};
            end
            default: begin
                next_state.rdata = 32'h00000000;
            end
        endcase

        // Clocks between microstep pulses; saturates at all ones at standstill.
        if (microstep_pulse) begin
            next_state.interval = (state.step_count == INTERVAL_MAX) ?
                INTERVAL_MAX : state.step_count + 20'h00001;
            next_state.step_count = '0;
        end else if (state.step_count == INTERVAL_MAX) begin
            next_state.interval = INTERVAL_MAX;
        end else begin
            next_state.step_count = state.step_count + 20'h00001;
        end

        // Any crossing of the high-speed threshold (re)starts suppression,
        // which then lasts a fixed count of microsteps.
        next_state.high_prev = under_high;
        unique case (state.sup_state)
            velocity_threshold_pkg::SUP_IDLE: begin
                if (crossing) begin
                    next_state.sup_state = velocity_threshold_pkg::SUP_ACTIVE;
                    next_state.sup_count = '0;
                end
            end
            velocity_threshold_pkg::SUP_ACTIVE: begin
                if (crossing) begin
                    next_state.sup_count = '0;
                end else if (microstep_pulse) begin
                    if (state.sup_count == SUP_LAST) begin
                        next_state.sup_state = velocity_threshold_pkg::SUP_IDLE;
                    end else begin
                        next_state.sup_count = state.sup_count + 12'h001;
                    end
                end
            end
            default: begin
                next_state.sup_state = velocity_threshold_pkg::SUP_IDLE;
            end
        endcase

        // Stall arming follows the lower threshold; in step mode it holds.
        if (under_low) begin
            next_state.stall_armed = 1'b1;
        end else if (!step_mode) begin
            next_state.stall_armed = 1'b0;
        end

        // Mode enables.
        next_state.scaling = current_scaling_config & under_low & ~under_high;
        next_state.stop_armed = stop_on_stall_enable & next_state.stall_armed;
        next_state.stall_out = stall_output_config & next_state.stall_armed;
        next_state.pwm_allowed = ~under_high;
        next_state.chm_one = under_high & high_speed_chopper_switch;
        next_state.decay_zero = under_high & high_speed_chopper_switch;
        next_state.full_step = under_high & high_speed_full_step;
        next_state.step_stall = step_mode;
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
            state.lower_velocity_threshold <= velocity_threshold_pkg::THRESHOLD_RESET;
            state.high_speed_threshold <= velocity_threshold_pkg::THRESHOLD_RESET;
            state.interval <= velocity_threshold_pkg::INTERVAL_RESET;
            state.sup_state <= velocity_threshold_pkg::SUP_IDLE;
            state.pwm_allowed <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops; stall_detect_suppressed decodes sup_state.
    assign reg_rdata = state.rdata;
    assign measured_step_interval = state.interval;
    assign current_scaling_active = state.scaling;
    assign stop_on_stall_armed = state.stop_armed;
    assign stall_to_diagnostic_outputs = state.stall_out;
    assign voltage_pwm_allowed = state.pwm_allowed;
    assign force_chopper_mode_one = state.chm_one;
    assign fast_decay_time_zero = state.decay_zero;
    assign full_step_active = state.full_step;
    assign step_mode_stall_detect = state.step_stall;
    assign stall_detect_suppressed = (state.sup_state == velocity_threshold_pkg::SUP_ACTIVE);

endmodule : velocity_threshold_mode_select

//--- tb/velocity_threshold_mode_select_sva.sv
// Assertion checker of the velocity threshold mode select block.
// Assumes it is bound to the block and sees only its ports, one clock domain.
`timescale 1ns/1ps
module velocity_threshold_mode_select_sva #(
    parameter int THR_W = 20
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] reg_addr,
    input wire logic reg_write,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic microstep_pulse,
    input wire logic current_scaling_config,
    input wire logic stop_on_stall_enable,
    input wire logic stall_output_config,
    input wire logic load_step_mode,
    input wire logic high_speed_chopper_switch,
    input wire logic high_speed_full_step,
    input wire logic [THR_W-1:0] measured_step_interval,
    input wire logic current_scaling_active,
    input wire logic stop_on_stall_armed,
    input wire logic stall_to_diagnostic_outputs,
    input wire logic voltage_pwm_allowed,
    input wire logic force_chopper_mode_one,
    input wire logic fast_decay_time_zero,
    input wire logic full_step_active,
    input wire logic step_mode_stall_detect,
    input wire logic stall_detect_suppressed
);
////////////////////////////////////////
    // All checks use the block clock and rest while reset is low.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Mode outputs are tied to the high region and the config bits of the cycle before.
    property p_chm;
        force_chopper_mode_one == (!voltage_pwm_allowed && $past(high_speed_chopper_switch));
    endproperty
    a_chm: assert property (p_chm) else $error("chopper select wrong");
    property p_tfd;
        fast_decay_time_zero == force_chopper_mode_one;
    endproperty
    a_tfd: assert property (p_tfd) else $error("fast decay override wrong");
    property p_full;
        full_step_active == (!voltage_pwm_allowed && $past(high_speed_full_step));
    endproperty
    a_full: assert property (p_full) else $error("full step wrong");
    property p_stepm;
        step_mode_stall_detect == ($past(load_step_mode) || full_step_active);
    endproperty
    a_stepm: assert property (p_stepm) else $error("step mode stall wrong");
    property p_scal;
        current_scaling_active |-> voltage_pwm_allowed && $past(current_scaling_config);
    endproperty
    a_scal: assert property (p_scal) else $error("scaling in high region");
    property p_scst;
        current_scaling_active && $past(stall_output_config) |->
            stall_to_diagnostic_outputs && (stop_on_stall_armed == $past(stop_on_stall_enable));
    endproperty
    a_scst: assert property (p_scst) else $error("stall not armed");
    property p_stop;
        stop_on_stall_armed |-> $past(stop_on_stall_enable);
    endproperty
    a_stop: assert property (p_stop) else $error("stop armed unset");
    property p_sup;
        $changed(voltage_pwm_allowed) |-> ##[0:2] stall_detect_suppressed;
    endproperty
    a_sup: assert property (p_sup) else $error("no stall suppression");
    property p_ivl;
        !$past(microstep_pulse) && !$past(microstep_pulse, 2) |->
            $stable(measured_step_interval) || (measured_step_interval == {THR_W{1'b1}});
    endproperty
    a_ivl: assert property (p_ivl) else $error("interval moved");
    property p_rd;
        (reg_write && reg_addr[6:1] == 6'h0B) ##1 (!reg_write && $stable(reg_addr)) |=>
            reg_rdata == ($past(reg_wdata, 2) & 32'h000FFFFF);
    endproperty
    a_rd: assert property (p_rd) else $error("threshold readback wrong");
endmodule : velocity_threshold_mode_select_sva

bind velocity_threshold_mode_select velocity_threshold_mode_select_sva #(
    .THR_W(THR_W)
) u_sva (.*);

//--- tb/velocity_threshold_mode_select_tb.sv
// Self-checking bench of the velocity threshold mode select block.
// Assumes the block alone, a 200 MHz clock and inputs driven 1 ns after edges.
`timescale 1ns/1ps
module velocity_threshold_mode_select_tb;
    typedef struct packed {
        logic [11:0] period;
        logic [3:0] flags;
        logic [7:0] modes;
    } row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic reg_write = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic microstep_pulse = 1'b0;
    logic small_hysteresis = 1'b0;
    logic current_scaling_config = 1'b1;
    logic stop_on_stall_enable = 1'b1;
    logic stall_output_config = 1'b1;
    logic load_step_mode = 1'b0;
    logic high_speed_chopper_switch = 1'b0;
    logic high_speed_full_step = 1'b0;
    logic [31:0] reg_rdata;
    logic [19:0] measured_step_interval;
    logic current_scaling_active, stop_on_stall_armed, stall_to_diagnostic_outputs;
    logic voltage_pwm_allowed, force_chopper_mode_one, fast_decay_time_zero;
    logic full_step_active, step_mode_stall_detect, stall_detect_suppressed;
    logic [7:0] modes;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    // Rows: step period, {narrow hyst, step mode, full step, chopper switch}, modes.
    row_t rows[14] = '{{12'h7D0, 4'h0, 8'h10}, {12'h60E, 4'h0, 8'h10},
        {12'h578, 4'h0, 8'hF0}, {12'h636, 4'h0, 8'hF0}, {12'h136, 4'h0, 8'hF0},
        {12'h0FA, 4'h1, 8'h6C}, {12'h0FA, 4'h2, 8'h63}, {12'h3E8, 4'h0, 8'hF0},
        {12'h7D0, 4'h0, 8'h10}, {12'h3E8, 4'h4, 8'hF1}, {12'h7D0, 4'h4, 8'h71},
        {12'h7D0, 4'h0, 8'h10}, {12'h5F0, 4'h8, 8'hF0}, {12'h7D0, 4'h8, 8'h10}};

    velocity_threshold_mode_select uut (.*);
////////////////////////////////////////
    // Clock, mode vector and the guard against a hang.
    always #2.5 clk = ~clk;
    assign modes = {current_scaling_active, stop_on_stall_armed, stall_to_diagnostic_outputs,
        voltage_pwm_allowed, force_chopper_mode_one, fast_decay_time_zero,
        full_step_active, step_mode_stall_detect};
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
////////////////////////////////////////
    // Prints the counts and the verdict, then stops the run.
    task automatic tally_and_finish();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_modes(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t modes got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_modes
    // Waits for n edges and steps 1 ns past the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic reg_wr(input logic [6:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        tick(1);
        reg_write = 1'b0;
    endtask : reg_wr
    // Read data is registered: it shows after the edge that samples the address.
    task automatic reg_chk(input logic [6:0] a, input logic [31:0] exp);
        reg_addr = a;
        tick(1);
        chk_word(reg_rdata, exp);
    endtask : reg_chk
    // Pulses that are p edges apart must measure an interval of p.
    task automatic pulses(input int p, input int n);
        repeat (n) begin
            microstep_pulse = 1'b1;
            tick(1);
            microstep_pulse = 1'b0;
            tick(p - 1);
        end
    endtask : pulses
////////////////////////////////////////
    initial begin
        tick(3);
        rst_b = 1'b1;
        chk_modes(modes, 8'h10);
        reg_chk(7'h16, 32'h00000000);
        reg_chk(7'h17, 32'h00000000);
        reg_wr(7'h16, 32'hFFF00640);
        reg_chk(7'h16, 32'h00000640);
        reg_wr(7'h17, 32'h00000140);
        reg_chk(7'h17, 32'h00000140);
        reg_wr(7'h14, 32'h00000123);
        reg_chk(7'h14, 32'h00000000);
        reg_chk(7'h20, 32'h00000000);
        foreach (rows[i]) begin
            {small_hysteresis, load_step_mode, high_speed_full_step,
                high_speed_chopper_switch} = rows[i].flags;
            pulses(int'(rows[i].period), 2);
            chk_word({12'h000, measured_step_interval}, {20'h00000, rows[i].period});
            chk_modes(modes, rows[i].modes);
        end
        // Crossing the high threshold both ways starts a suppression of 2048 steps.
        reg_wr(7'h17, 32'h00000028);
        pulses(10, 8);
        chk_word({31'h00000000, stall_detect_suppressed}, 32'h00000001);
        // After 2046 counted steps it still holds; a few steps later it has ended.
        pulses(10, 2040);
        chk_word({31'h00000000, stall_detect_suppressed}, 32'h00000001);
        pulses(10, 20);
        chk_word({31'h00000000, stall_detect_suppressed}, 32'h00000000);
        pulses(60, 3);
        chk_word({31'h00000000, stall_detect_suppressed}, 32'h00000001);
        // Unconfigured features stay off below the lower threshold.
        current_scaling_config = 1'b0;
        stop_on_stall_enable = 1'b0;
        stall_output_config = 1'b0;
        tick(2);
        chk_modes(modes, 8'h10);
        // A second reset clears the modes except voltage_pwm_allowed, and both thresholds.
        rst_b = 1'b0;
        tick(1);
        chk_modes(modes, 8'h10);
        rst_b = 1'b1;
        reg_chk(7'h16, 32'h00000000);
        reg_chk(7'h17, 32'h00000000);
        tally_and_finish();
    end
endmodule : velocity_threshold_mode_select_tb
